// *** flash_power_pkg.sv ***
// constants and state encoding for the flash power mode sequencer
package flash_power_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int SYS_CLK_PERIOD_NS = 20;
	localparam int SLEEP_ENTRY_TIME_NS = 10000;
	localparam int SLEEP_WAKE_TIME_US = 300;
	localparam int RESET_PULSE_WIDTH_NS = 200;
	localparam int INITIAL_ACCESS_TIME_NS = 96;
	localparam int CLOCK_STOP_MARGIN_NS = 30;
	localparam int POR_HOLD_TIME_US = 300;

	// least times round up, longest times round down
	localparam int ENTRY_CYCLES = (SLEEP_ENTRY_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int WAKE_CYCLES = (SLEEP_WAKE_TIME_US * 1000) / SYS_CLK_PERIOD_NS;
	localparam int RESET_PULSE_CYCLES = (RESET_PULSE_WIDTH_NS + SYS_CLK_PERIOD_NS - 1)
		/ SYS_CLK_PERIOD_NS;
	localparam int CLOCK_STOP_CYCLES = (INITIAL_ACCESS_TIME_NS + CLOCK_STOP_MARGIN_NS
		+ SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int POR_HOLD_CYCLES = (POR_HOLD_TIME_US * 1000) / SYS_CLK_PERIOD_NS;

	// ----------------------------------------
	// widths and reset values
	// ----------------------------------------
	localparam int TIMER_WIDTH = 16;
	localparam int PULSE_CNT_WIDTH = 8;
	localparam int STOP_CNT_WIDTH = 4;
	localparam int SYNC_BITS = 6;
	localparam logic [SYNC_BITS-1:0] SYNC_RESET = 6'h28;

	// ----------------------------------------
	// power states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_POR,
		ST_STANDBY,
		ST_ENTRY,
		ST_SLEEP,
		ST_WAKE
	} power_state_t;

endpackage : flash_power_pkg

// *** sync_two_stage.sv ***
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module sync_two_stage #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// clock and reset
	input wire logic sysClk,
	input wire logic rstn,
	// data
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge sysClk or negedge rstn)
	begin
		if (!rstn)
		begin
			stage1_reg <= INIT;
			syncOut <= INIT;
		end
		else
		begin
			stage1_reg <= asyncIn;
			syncOut <= stage1_reg;
		end
	end

endmodule : sync_two_stage

// *** flash_power_mode_sequencer.sv ***
// power state sequencer: lock-out, power-on reset, deep sleep, active clock stop
`timescale 1ns/1ps
module flash_power_mode_sequencer #(
	parameter int WAKE_TIME_CYCLES = flash_power_pkg::WAKE_CYCLES,
	parameter int POR_TIME_CYCLES = flash_power_pkg::POR_HOLD_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// pins from the host
	input wire logic csN,
	input wire logic linkClk,
	input wire logic hwResetN,
	// supply monitors
	input wire logic supplyAboveLockout,
	input wire logic supplyAboveResetLevel,
	input wire logic supplyAtMin,
	// command decoder
	input wire logic sleepEntryCmd,
	input wire logic inAlternateSpace,
	input wire logic transferActive,
	// state outputs
	output logic cmdAccept,
	output logic strobeEnable,
	output logic programEraseEnable,
	output logic sleepActive,
	output logic coldResetStart,
	output logic restoreDefaults,
	// clock stop outputs
	output logic clockStopActive,
	output logic readDataHold,
	output logic transferResume,
	// open-drain system reset
	output logic systemResetOutNOut,
	output logic systemResetOutNOe
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		flash_power_pkg::power_state_t fsm;
		logic [flash_power_pkg::TIMER_WIDTH-1:0] timer;
		logic [flash_power_pkg::PULSE_CNT_WIDTH-1:0] rpCnt;
		logic [flash_power_pkg::STOP_CNT_WIDTH-1:0] stopCnt;
		logic ckPrev;
		logic dipSeen;
		logic cmdAccept;
		logic strobeEnable;
		logic progErase;
		logic sleepActive;
		logic coldStart;
		logic restore;
		logic clockStop;
		logic resume;
		logic resetOutOe;
	} seq_state_t;

	localparam seq_state_t STATE_RESET = '{
		fsm: flash_power_pkg::ST_POR,
		timer: '0,
		rpCnt: '0,
		stopCnt: '0,
		ckPrev: 1'b0,
		dipSeen: 1'b0,
		cmdAccept: 1'b0,
		strobeEnable: 1'b0,
		progErase: 1'b0,
		sleepActive: 1'b0,
		coldStart: 1'b0,
		restore: 1'b0,
		clockStop: 1'b0,
		resume: 1'b0,
		resetOutOe: 1'b1
	};

	localparam logic [flash_power_pkg::TIMER_WIDTH-1:0] ENTRY_LAST =
		flash_power_pkg::TIMER_WIDTH'(flash_power_pkg::ENTRY_CYCLES - 1);
	localparam logic [flash_power_pkg::TIMER_WIDTH-1:0] WAKE_LAST =
		flash_power_pkg::TIMER_WIDTH'(WAKE_TIME_CYCLES - 1);
	localparam logic [flash_power_pkg::TIMER_WIDTH-1:0] POR_LAST =
		flash_power_pkg::TIMER_WIDTH'(POR_TIME_CYCLES - 1);
	localparam logic [flash_power_pkg::PULSE_CNT_WIDTH-1:0] PULSE_FULL =
		flash_power_pkg::PULSE_CNT_WIDTH'(flash_power_pkg::RESET_PULSE_CYCLES);
	localparam logic [flash_power_pkg::STOP_CNT_WIDTH-1:0] STOP_LAST =
		flash_power_pkg::STOP_CNT_WIDTH'(flash_power_pkg::CLOCK_STOP_CYCLES - 1);

	seq_state_t r_reg;
	seq_state_t r_next;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [flash_power_pkg::SYNC_BITS-1:0] syncBits;
	logic csNSync;
	logic ckSync;
	logic hwResetNSync;
	logic lockoutOkSync;
	logic resetLevelOkSync;
	logic atMinSync;

	sync_two_stage #(
		.WIDTH(flash_power_pkg::SYNC_BITS),
		.INIT(flash_power_pkg::SYNC_RESET)
	) inputSync (
		.sysClk(sys_clk),
		.rstn(rstn),
		.asyncIn({csN, linkClk, hwResetN, supplyAboveLockout, supplyAboveResetLevel,
			supplyAtMin}),
		.syncOut(syncBits)
	);

	assign {csNSync, ckSync, hwResetNSync, lockoutOkSync, resetLevelOkSync, atMinSync} =
		syncBits;

	logic pulseValid;
	logic dipRecover;
	logic ckEdge;

	assign pulseValid = (r_reg.rpCnt == PULSE_FULL);
	assign dipRecover = r_reg.dipSeen && atMinSync;
	assign ckEdge = ckSync ^ r_reg.ckPrev;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		r_next = r_reg;
		r_next.coldStart = 1'b0;
		r_next.restore = 1'b0;
		r_next.resume = 1'b0;
		r_next.ckPrev = ckSync;
		// hardware reset pulse width qualification
		if (!hwResetNSync)
		begin
			if (r_reg.rpCnt != PULSE_FULL)
				r_next.rpCnt = r_reg.rpCnt + 1'b1;
		end
		else
			r_next.rpCnt = '0;
		if (!resetLevelOkSync)
			r_next.dipSeen = 1'b1;
		unique case (r_reg.fsm)
			flash_power_pkg::ST_POR:
			begin
				r_next.timer = r_reg.timer + 1'b1;
				if (r_reg.timer == POR_LAST)
					r_next.fsm = flash_power_pkg::ST_STANDBY;
			end
			flash_power_pkg::ST_STANDBY:
			begin
				if (sleepEntryCmd && !inAlternateSpace)
				begin
					r_next.fsm = flash_power_pkg::ST_ENTRY;
					r_next.timer = '0;
				end
			end
			flash_power_pkg::ST_ENTRY:
			begin
				r_next.timer = r_reg.timer + 1'b1;
				if (pulseValid)
					r_next.fsm = flash_power_pkg::ST_STANDBY;
				else if (r_reg.timer == ENTRY_LAST)
					r_next.fsm = flash_power_pkg::ST_SLEEP;
			end
			flash_power_pkg::ST_SLEEP:
			begin
				if (!csNSync || pulseValid)
				begin
					r_next.fsm = flash_power_pkg::ST_WAKE;
					r_next.timer = '0;
				end
			end
			flash_power_pkg::ST_WAKE:
			begin
				r_next.timer = r_reg.timer + 1'b1;
				if (r_reg.timer == WAKE_LAST)
				begin
					r_next.fsm = flash_power_pkg::ST_STANDBY;
					r_next.restore = 1'b1;
				end
			end
			default:
				r_next.fsm = flash_power_pkg::ST_POR;
		endcase
		// supply dip and recovery overrides every state transition
		if (dipRecover)
		begin
			r_next.fsm = flash_power_pkg::ST_POR;
			r_next.timer = '0;
			r_next.coldStart = 1'b1;
			r_next.dipSeen = !resetLevelOkSync;
		end
		// active clock stop during data transfer
		if (!transferActive || r_reg.fsm != flash_power_pkg::ST_STANDBY)
		begin
			r_next.stopCnt = '0;
			r_next.clockStop = 1'b0;
		end
		else if (ckEdge)
		begin
			r_next.stopCnt = '0;
			r_next.clockStop = 1'b0;
			r_next.resume = r_reg.clockStop;
		end
		else if (!ckSync && !r_reg.clockStop)
		begin
			if (r_reg.stopCnt == STOP_LAST)
				r_next.clockStop = 1'b1;
			else
				r_next.stopCnt = r_reg.stopCnt + 1'b1;
		end
		// registered outputs
		r_next.cmdAccept = (r_next.fsm == flash_power_pkg::ST_STANDBY);
		r_next.strobeEnable = (r_next.fsm == flash_power_pkg::ST_STANDBY);
		r_next.progErase = lockoutOkSync && (r_next.fsm == flash_power_pkg::ST_STANDBY);
		r_next.sleepActive = (r_next.fsm == flash_power_pkg::ST_SLEEP);
		r_next.resetOutOe = (r_next.fsm == flash_power_pkg::ST_POR);
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			r_reg <= STATE_RESET;
		else
			r_reg <= r_next;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign cmdAccept = r_reg.cmdAccept;
	assign strobeEnable = r_reg.strobeEnable;
	assign programEraseEnable = r_reg.progErase;
	assign sleepActive = r_reg.sleepActive;
	assign coldResetStart = r_reg.coldStart;
	assign restoreDefaults = r_reg.restore;
	assign clockStopActive = r_reg.clockStop;
	assign readDataHold = r_reg.clockStop;
	assign transferResume = r_reg.resume;
	assign systemResetOutNOut = 1'b0;
	assign systemResetOutNOe = r_reg.resetOutOe;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	lockout_refuse_a: assert property (!lockoutOkSync |=> !programEraseEnable)
		else $error("program or erase allowed below lock-out");
	dip_cold_reset_a: assert property (dipRecover |=> coldResetStart && r_reg.fsm ==
		flash_power_pkg::ST_POR && systemResetOutNOe)
		else $error("supply recovery did not start power-on reset");
	entry_min_time_a: assert property ((r_reg.fsm == flash_power_pkg::ST_ENTRY &&
		r_next.fsm == flash_power_pkg::ST_SLEEP) |-> r_reg.timer == ENTRY_LAST)
		else $error("deep sleep reached before entry time");
	entry_ignore_a: assert property (r_reg.fsm == flash_power_pkg::ST_ENTRY && !csNSync
		&& !pulseValid && !dipRecover && r_reg.timer != ENTRY_LAST
		|=> r_reg.fsm == flash_power_pkg::ST_ENTRY && !cmdAccept)
		else $error("entry disturbed by chip select or command");
	wake_quiet_a: assert property (r_reg.fsm == flash_power_pkg::ST_WAKE
		|-> !strobeEnable && !cmdAccept && r_reg.timer <= WAKE_LAST)
		else $error("strobe or command during wake");
	reset_exit_a: assert property (r_reg.fsm == flash_power_pkg::ST_SLEEP && pulseValid
		&& !dipRecover |=> r_reg.fsm == flash_power_pkg::ST_WAKE)
		else $error("reset pulse did not wake from sleep");
	entry_abort_a: assert property (r_reg.fsm == flash_power_pkg::ST_ENTRY && pulseValid
		&& !dipRecover |=> r_reg.fsm == flash_power_pkg::ST_STANDBY && cmdAccept)
		else $error("reset pulse did not abort entry");
	restore_exit_a: assert property (r_reg.fsm == flash_power_pkg::ST_WAKE && r_next.fsm
		== flash_power_pkg::ST_STANDBY |=> restoreDefaults ##1 !restoreDefaults)
		else $error("defaults not restored on wake completion");
	clock_stop_a: assert property (r_reg.fsm == flash_power_pkg::ST_STANDBY && transferActive
		&& !dipRecover && !ckEdge && !ckSync && r_reg.stopCnt == STOP_LAST
		|=> clockStopActive && readDataHold)
		else $error("clock stop not entered after stable clock");
	resume_a: assert property (clockStopActive && ckEdge && transferActive
		&& r_reg.fsm == flash_power_pkg::ST_STANDBY |=> transferResume && !clockStopActive)
		else $error("transfer did not resume on clock toggle");
	por_block_a: assert property (systemResetOutNOe |-> !cmdAccept)
		else $error("command accepted while reset output low");
	cs_wake_a: assert property (r_reg.fsm == flash_power_pkg::ST_SLEEP && !csNSync
		&& !dipRecover |=> r_reg.fsm == flash_power_pkg::ST_WAKE)
		else $error("chip select did not wake from sleep");

	sleep_entered_c: cover property (r_reg.fsm == flash_power_pkg::ST_ENTRY
		##1 r_reg.fsm == flash_power_pkg::ST_SLEEP);
	wake_done_c: cover property (restoreDefaults);
	abort_c: cover property (r_reg.fsm == flash_power_pkg::ST_ENTRY
		##1 r_reg.fsm == flash_power_pkg::ST_STANDBY);
	clock_stop_c: cover property (clockStopActive ##[1:50] transferResume);

endmodule : flash_power_mode_sequencer

// *** host_model.sv ***
// host controller model: chip select, link clock and hardware reset pins
`timescale 1ns/1ps
module host_model (
	// clock
	input wire logic sys_clk,
	// pins to the device
	output logic csN,
	output logic linkClk,
	output logic hwResetN
);
	// ----------------------------------------
	// idle pins: clock parked low outside frames
	// ----------------------------------------
	initial
	begin
		csN = 1'b1;
		linkClk = 1'b0;
		hwResetN = 1'b1;
	end

	// ----------------------------------------
	// pin tasks
	// ----------------------------------------
	// chip select low for n cycles; used both during entry and in sleep
	task automatic cs_pulse(input int n);
		@(posedge sys_clk);
		csN <= 1'b0;
		repeat (n) @(posedge sys_clk);
		csN <= 1'b1;
	endtask : cs_pulse

	task automatic rst_pulse(input int n);
		@(posedge sys_clk);
		hwResetN <= 1'b0;
		repeat (n) @(posedge sys_clk);
		hwResetN <= 1'b1;
	endtask : rst_pulse

	// n periods of 160 ns, always left parked low
	task automatic run_clk(input int n);
		repeat (n)
		begin
			@(posedge sys_clk);
			linkClk <= 1'b1;
			repeat (4) @(posedge sys_clk);
			linkClk <= 1'b0;
			repeat (3) @(posedge sys_clk);
		end
	endtask : run_clk

	task automatic park_high();
		@(posedge sys_clk);
		linkClk <= 1'b1;
	endtask : park_high
endmodule : host_model

// *** tb_top.sv ***
// testbench for the flash power mode sequencer
`timescale 1ns/1ps
module tb_top;
	logic sys_clk, rstn, csN, linkClk, hwResetN;
	logic supplyAboveLockout, supplyAboveResetLevel, supplyAtMin;
	logic sleepEntryCmd, inAlternateSpace, transferActive;
	logic cmdAccept, strobeEnable, programEraseEnable, sleepActive, coldResetStart;
	logic restoreDefaults, clockStopActive, readDataHold, transferResume;
	logic systemResetOutNOut, systemResetOutNOe;
	int nFail = 0;
	int checkCount = 0;
	int nRestore = 0;
	int nCold = 0;
	int nResume = 0;
	int r0, c0, m0;

	// ----------------------------------------
	// clock, reset, instances
	// ----------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	host_model HOST (.sys_clk(sys_clk), .csN(csN), .linkClk(linkClk), .hwResetN(hwResetN));

	flash_power_mode_sequencer #(.WAKE_TIME_CYCLES(40), .POR_TIME_CYCLES(20)) DUT (
		.sys_clk(sys_clk), .rstn(rstn), .csN(csN), .linkClk(linkClk), .hwResetN(hwResetN),
		.supplyAboveLockout(supplyAboveLockout), .supplyAboveResetLevel(supplyAboveResetLevel),
		.supplyAtMin(supplyAtMin), .sleepEntryCmd(sleepEntryCmd),
		.inAlternateSpace(inAlternateSpace), .transferActive(transferActive),
		.cmdAccept(cmdAccept), .strobeEnable(strobeEnable),
		.programEraseEnable(programEraseEnable), .sleepActive(sleepActive),
		.coldResetStart(coldResetStart), .restoreDefaults(restoreDefaults),
		.clockStopActive(clockStopActive), .readDataHold(readDataHold),
		.transferResume(transferResume), .systemResetOutNOut(systemResetOutNOut),
		.systemResetOutNOe(systemResetOutNOe));

	always @(posedge sys_clk)
	begin
		if (restoreDefaults === 1'b1) nRestore++;
		if (coldResetStart === 1'b1) nCold++;
		if (transferResume === 1'b1) nResume++;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checkCount++;
		if (got !== exp)
		begin
			nFail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic nx(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : nx

	task automatic mid();
		@(negedge sys_clk);
	endtask : mid

	task automatic enter_sleep();
		@(posedge sys_clk);
		sleepEntryCmd <= 1'b1;
		@(posedge sys_clk);
		sleepEntryCmd <= 1'b0;
	endtask : enter_sleep

	task automatic wrapUp();
		$display("checks %0d mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrapUp

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_por();
		for (int i = 0; i < 100 && cmdAccept !== 1'b1; i++) nx(1);
		mid();
		check(cmdAccept, 1);
		check(systemResetOutNOe, 0);
		check(systemResetOutNOut, 0);
		check(programEraseEnable, 1);
		check(strobeEnable, 1);
	endtask : t_por

	task automatic t_lockout();
		@(posedge sys_clk);
		supplyAboveLockout <= 1'b0;
		nx(5);
		mid();
		check(programEraseEnable, 0);
		check(cmdAccept, 1);
		@(posedge sys_clk);
		supplyAboveLockout <= 1'b1;
		nx(5);
		mid();
		check(programEraseEnable, 1);
	endtask : t_lockout

	task automatic t_alt_space();
		@(posedge sys_clk);
		inAlternateSpace <= 1'b1;
		enter_sleep();
		inAlternateSpace <= 1'b0;
		nx(3);
		mid();
		check(cmdAccept, 1);
	endtask : t_alt_space

	task automatic t_sleep_cs();
		r0 = nRestore;
		enter_sleep();
		mid();
		check({cmdAccept, strobeEnable, programEraseEnable}, 0);
		nx(98);
		enter_sleep();
		HOST.cs_pulse(20);
		nx(366);
		mid();
		check(sleepActive, 0);
		nx(20);
		mid();
		check(sleepActive, 1);
		HOST.cs_pulse(4);
		nx(2);
		mid();
		check({sleepActive, cmdAccept, strobeEnable}, 0);
		enter_sleep();
		nx(45);
		mid();
		check(nRestore - r0, 1);
		check({cmdAccept, strobeEnable, sleepActive}, 3'h6);
	endtask : t_sleep_cs

	task automatic t_abort();
		r0 = nRestore;
		enter_sleep();
		nx(100);
		HOST.rst_pulse(12);
		nx(450);
		mid();
		check({sleepActive, cmdAccept}, 2'h1);
		check(nRestore - r0, 0);
	endtask : t_abort

	task automatic t_sleep_rst();
		r0 = nRestore;
		enter_sleep();
		nx(510);
		mid();
		check(sleepActive, 1);
		HOST.rst_pulse(12);
		nx(3);
		mid();
		check({sleepActive, cmdAccept}, 0);
		nx(50);
		mid();
		check(nRestore - r0, 1);
		check(cmdAccept, 1);
	endtask : t_sleep_rst

	task automatic t_dip();
		c0 = nCold;
		@(posedge sys_clk);
		supplyAboveResetLevel <= 1'b0;
		supplyAtMin <= 1'b0;
		nx(5);
		supplyAboveResetLevel <= 1'b1;
		nx(3);
		supplyAtMin <= 1'b1;
		nx(6);
		mid();
		check(nCold - c0, 1);
		check({systemResetOutNOe, cmdAccept}, 2'h2);
		nx(40);
		mid();
		check({systemResetOutNOe, cmdAccept}, 2'h1);
	endtask : t_dip

	task automatic t_clock_stop();
		m0 = nResume;
		@(posedge sys_clk);
		transferActive <= 1'b1;
		HOST.run_clk(3);
		mid();
		check(clockStopActive, 0);
		nx(12);
		mid();
		check({clockStopActive, readDataHold}, 2'h3);
		HOST.run_clk(1);
		mid();
		check(nResume - m0, 1);
		check(clockStopActive, 0);
		HOST.park_high();
		nx(20);
		mid();
		check(clockStopActive, 0);
		HOST.run_clk(1);
		nx(12);
		@(posedge sys_clk);
		transferActive <= 1'b0;
		nx(2);
		mid();
		check({clockStopActive, readDataHold}, 0);
		check(nResume - m0, 1);
	endtask : t_clock_stop

	task automatic t_mid_reset();
		enter_sleep();
		nx(10);
		rstn <= 1'b0;
		nx(2);
		mid();
		check({systemResetOutNOe, cmdAccept, sleepActive, programEraseEnable}, 4'h8);
		@(posedge sys_clk);
		rstn <= 1'b1;
		nx(2);
		mid();
		check({systemResetOutNOe, cmdAccept}, 2'h2);
		for (int i = 0; i < 100 && cmdAccept !== 1'b1; i++) nx(1);
		mid();
		check({systemResetOutNOe, cmdAccept, sleepActive}, 3'h2);
	endtask : t_mid_reset

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		rstn = 1'b0;
		supplyAboveLockout = 1'b1;
		supplyAboveResetLevel = 1'b1;
		supplyAtMin = 1'b1;
		sleepEntryCmd = 1'b0;
		inAlternateSpace = 1'b0;
		transferActive = 1'b0;
		nx(16);
		rstn <= 1'b1;
		t_por();
		t_lockout();
		t_alt_space();
		t_sleep_cs();
		t_abort();
		t_sleep_rst();
		t_mid_reset();
		t_dip();
		t_clock_stop();
		wrapUp();
	end

	initial
	begin
		nx(20000);
		nFail++;
		wrapUp();
	end
endmodule : tb_top
